/* File: ldcs_top.sv */
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`include "ldcs_regs.svh"
// Functional notes
// [R1] sequence ratio computed for own end and for received remote values
// [R2] ratio non-zero at both ends means network fault, no alarm
// [R3] ratio non-zero at one end only allows supervision to operate
// [R4] supervision needs load current at both ends
// [R5] indication mode raises alarm, tripping unchanged
// [R6] restrain mode raises alarm and doubles differential pick-up
// [R7] block mode raises alarm and inhibits differential trip
// [R8] software should avoid block mode; line may stay unprotected
// [R9] supervision lives in the stage and uses link remote measurements
// [R10] sixteen binary signal slots shared by both relays
// [R11] signal status sent over the link every 10 ms
// [R12] each slot picks none, virtual input, virtual output or logic output
// [R13] signals transfer only while instance enabled on both relays
// [R14] slot n active at sender drives remote signal n here
// [R15] link status: proto absent, disabled or ok
// [R16] fixed frequency mode makes frequency stages unavailable
// [R17] fifth harmonic block limit defaults to 35 percent
// [R18] separately enabled second harmonic block suppresses trips
// [R19] link failure deactivates differential protection
// [R20] trip after two consecutive task cycles over threshold
// [R21] ratio below small threshold counts as zero at both ends
// [R22] two-bit mode setting; alarm clears when failure goes away
module ldcs_top #(
  parameter int TX_PERIOD_CYC = `LDCS_TX_PERIOD_MS * `LDCS_CLK_KHZ,
  parameter int RX_TIMEOUT_CYC = `LDCS_RX_TIMEOUT_MS * `LDCS_CLK_KHZ
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // local measurements, task cycle
  input wire logic i_task_tick,
  input wire logic [15:0] i_own_pos_seq,
  input wire logic [15:0] i_own_neg_seq,
  input wire logic [15:0] i_diff_cur,
  input wire logic [7:0] i_h2_pct,
  input wire logic [7:0] i_h5_pct,
  // slot sources
  input wire logic [3:0] i_virtual_input,
  input wire logic [5:0] i_virtual_output,
  input wire logic [19:0] i_logic_out,
  // link receive side
  input wire logic i_proto_assigned,
  input wire logic i_rx_valid,
  input wire logic i_rx_enabled,
  input wire logic [15:0] i_rx_pos_seq,
  input wire logic [15:0] i_rx_neg_seq,
  input wire logic [15:0] i_rx_signals,
  // link transmit side
  output logic o_tx_valid,
  output logic o_tx_enabled,
  output logic [15:0] o_tx_pos_seq,
  output logic [15:0] o_tx_neg_seq,
  output logic [15:0] o_tx_signals,
  // protection outputs
  output logic [15:0] o_remote_binary_signal,
  output logic [1:0] o_link_status,
  output logic o_comm_fail,
  output logic o_cts_alarm,
  output logic o_trip,
  output logic o_freq_stage_avail
);
  // ==================================
  // register file
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [`LDCS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [7:0] ratio_thr_r, ratio_thr_nxt, h5_lim_r, h5_lim_nxt, h2_lim_r, h2_lim_nxt;
  logic [15:0] pickup_r, pickup_nxt, load_thr_r, load_thr_nxt;
  logic [6:0] slot_cfg_r [`LDCS_SLOTS], slot_cfg_nxt [`LDCS_SLOTS];
  logic wr_en, rd_en;
  logic [31:0] ev_clr;
  logic [31:0] ev_r, ev_nxt;
  logic [15:0] rem_sig_r, rem_sig_nxt;
  logic [1:0] link_st_r, link_st_nxt;
  logic comm_fail_r, comm_fail_nxt, alarm_r, alarm_nxt, trip_r, trip_nxt;
  ldcs_pkg::ldcs_mode_e mode;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r;
  assign rd_en = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_r;
  assign mode = ldcs_pkg::ldcs_mode_e'(ctrl_r[`LDCS_CTRL_MODE_LO +: 2]); // R22

  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    ack_nxt = i_wb_cyc && i_wb_stb && !ack_r;
    rdat_nxt = rdat_r;
    ctrl_nxt = ctrl_r;
    ratio_thr_nxt = ratio_thr_r;
    pickup_nxt = pickup_r;
    h5_lim_nxt = h5_lim_r;
    h2_lim_nxt = h2_lim_r;
    load_thr_nxt = load_thr_r;
    slot_cfg_nxt = slot_cfg_r;
    ev_clr = 32'h0000_0000;
    if (wr_en) begin
      if (i_wb_adr == `LDCS_CTRL_OFS) begin
        m = merge({25'h0, ctrl_r}, i_wb_dat, i_wb_sel);
        ctrl_nxt = m[`LDCS_CTRL_W-1:0];
      end else if (i_wb_adr == `LDCS_RATIO_THR_OFS) begin
        m = merge({24'h0, ratio_thr_r}, i_wb_dat, i_wb_sel);
        ratio_thr_nxt = m[7:0];
      end else if (i_wb_adr == `LDCS_PICKUP_OFS) begin
        m = merge({16'h0, pickup_r}, i_wb_dat, i_wb_sel);
        pickup_nxt = m[15:0];
      end else if (i_wb_adr == `LDCS_H5_LIM_OFS) begin
        m = merge({24'h0, h5_lim_r}, i_wb_dat, i_wb_sel);
        h5_lim_nxt = m[7:0];
      end else if (i_wb_adr == `LDCS_H2_LIM_OFS) begin
        m = merge({24'h0, h2_lim_r}, i_wb_dat, i_wb_sel);
        h2_lim_nxt = m[7:0];
      end else if (i_wb_adr == `LDCS_LOAD_THR_OFS) begin
        m = merge({16'h0, load_thr_r}, i_wb_dat, i_wb_sel);
        load_thr_nxt = m[15:0];
      end else if (i_wb_adr == `LDCS_EVENT_OFS) begin
        ev_clr = merge(32'h0000_0000, i_wb_dat, i_wb_sel);
      end else if (i_wb_adr[7:6] == `LDCS_SLOT_BASE) begin
        m = merge({25'h0, slot_cfg_r[i_wb_adr[5:2]]}, i_wb_dat, i_wb_sel);
        slot_cfg_nxt[i_wb_adr[5:2]] = m[6:0];
      end
    end
    if (rd_en) begin
      if (i_wb_adr == `LDCS_CTRL_OFS) begin
        rdat_nxt = {25'h0, ctrl_r};
      end else if (i_wb_adr == `LDCS_RATIO_THR_OFS) begin
        rdat_nxt = {24'h0, ratio_thr_r};
      end else if (i_wb_adr == `LDCS_PICKUP_OFS) begin
        rdat_nxt = {16'h0, pickup_r};
      end else if (i_wb_adr == `LDCS_H5_LIM_OFS) begin
        rdat_nxt = {24'h0, h5_lim_r};
      end else if (i_wb_adr == `LDCS_H2_LIM_OFS) begin
        rdat_nxt = {24'h0, h2_lim_r};
      end else if (i_wb_adr == `LDCS_LOAD_THR_OFS) begin
        rdat_nxt = {16'h0, load_thr_r};
      end else if (i_wb_adr == `LDCS_STATUS_OFS) begin
        rdat_nxt = {26'h0, link_st_r, trip_r, alarm_r, comm_fail_r, 1'b0};
      end else if (i_wb_adr == `LDCS_REMOTE_OFS) begin
        rdat_nxt = {16'h0, rem_sig_r};
      end else if (i_wb_adr == `LDCS_EVENT_OFS) begin
        rdat_nxt = ev_r;
      end else if (i_wb_adr[7:6] == `LDCS_SLOT_BASE) begin
        rdat_nxt = {25'h0, slot_cfg_r[i_wb_adr[5:2]]};
      end else begin
        rdat_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      ctrl_r <= `LDCS_CTRL_RST;
      ratio_thr_r <= `LDCS_RATIO_THR_RST;
      pickup_r <= `LDCS_PICKUP_RST;
      h5_lim_r <= `LDCS_H5_LIM_RST; // R17
      h2_lim_r <= `LDCS_H2_LIM_RST;
      load_thr_r <= `LDCS_LOAD_THR_RST;
      for (int s = 0; s < `LDCS_SLOTS; s++) begin
        slot_cfg_r[s] <= 7'h00;
      end
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      ctrl_r <= ctrl_nxt;
      ratio_thr_r <= ratio_thr_nxt;
      pickup_r <= pickup_nxt;
      h5_lim_r <= h5_lim_nxt;
      h2_lim_r <= h2_lim_nxt;
      load_thr_r <= load_thr_nxt;
      slot_cfg_r <= slot_cfg_nxt;
    end
  end

  // ==================================
  // slot source selection
  function automatic logic src_bit(input logic [4:0] code, input logic [3:0] vi,
                                   input logic [5:0] vo, input logic [19:0] lg);
    int c;
    c = int'(code);
    if (c >= `LDCS_SRC_LG_FIRST && c <= `LDCS_SRC_LAST) begin
      return lg[c - `LDCS_SRC_LG_FIRST];
    end else if (c >= `LDCS_SRC_VO_FIRST) begin
      return (c < `LDCS_SRC_LG_FIRST) ? vo[c - `LDCS_SRC_VO_FIRST] : 1'b0;
    end else if (c >= `LDCS_SRC_VI_FIRST) begin
      return vi[c - `LDCS_SRC_VI_FIRST];
    end
    return 1'b0;
  endfunction

  logic [15:0] slot_val;
  logic [15:0] on_en, off_en;
  genvar g;
  generate
    for (g = 0; g < `LDCS_SLOTS; g++) begin : g_slot
      assign slot_val[g] = src_bit(slot_cfg_r[g][4:0], i_virtual_input, // R12
                                   i_virtual_output, i_logic_out);
      assign on_en[g] = slot_cfg_r[g][5];
      assign off_en[g] = slot_cfg_r[g][6];
    end
  endgenerate

  // ==================================
  // protection link
  logic [17:0] tx_cnt_r, tx_cnt_nxt;
  logic [19:0] rx_to_r, rx_to_nxt;
  logic tx_valid_r, tx_valid_nxt, rem_en_r, rem_en_nxt;
  logic txen_r, txen_nxt;
  logic [15:0] tx_sig_r, tx_sig_nxt, prev_r, prev_nxt;
  logic [15:0] rem_pos_r, rem_pos_nxt, rem_neg_r, rem_neg_nxt;
  logic [15:0] own_pos_r, own_pos_nxt, own_neg_r, own_neg_nxt;
  logic link_ok, xfer_ok;

  assign link_ok = (link_st_r == ldcs_pkg::LDCS_LINK_OK);
  assign xfer_ok = link_ok && rem_en_r && !comm_fail_r;

  always_comb begin
    if (!i_proto_assigned) begin
      link_st_nxt = ldcs_pkg::LDCS_LINK_PROTO_ABSENT; // R15
    end else if (!ctrl_r[`LDCS_CTRL_LINK_EN]) begin
      link_st_nxt = ldcs_pkg::LDCS_LINK_DISABLED;
    end else begin
      link_st_nxt = ldcs_pkg::LDCS_LINK_OK;
    end
    // registered copy so the pin comes straight from a flop
    txen_nxt = (link_st_nxt == ldcs_pkg::LDCS_LINK_OK); // R13
    tx_valid_nxt = 1'b0;
    tx_cnt_nxt = tx_cnt_r;
    tx_sig_nxt = tx_sig_r;
    own_pos_nxt = own_pos_r;
    own_neg_nxt = own_neg_r;
    if (!link_ok) begin
      tx_cnt_nxt = 18'h0;
    end else if (int'(tx_cnt_r) >= TX_PERIOD_CYC - 1) begin
      tx_cnt_nxt = 18'h0; // R11
      tx_valid_nxt = 1'b1;
      tx_sig_nxt = slot_val; // R10
      own_pos_nxt = i_own_pos_seq; // R9
      own_neg_nxt = i_own_neg_seq;
    end else begin
      tx_cnt_nxt = tx_cnt_r + 18'h1;
    end
    rem_en_nxt = rem_en_r;
    rem_pos_nxt = rem_pos_r;
    rem_neg_nxt = rem_neg_r;
    rem_sig_nxt = xfer_ok ? rem_sig_r : 16'h0; // R13
    rx_to_nxt = rx_to_r;
    if (i_rx_valid && link_ok) begin
      rx_to_nxt = 20'h0;
      rem_en_nxt = i_rx_enabled;
      rem_pos_nxt = i_rx_pos_seq;
      rem_neg_nxt = i_rx_neg_seq;
      rem_sig_nxt = (i_rx_enabled && !comm_fail_r) ? i_rx_signals : 16'h0; // R14
    end else if (int'(rx_to_r) < RX_TIMEOUT_CYC) begin
      rx_to_nxt = rx_to_r + 20'h1;
    end
    comm_fail_nxt = !link_ok || (int'(rx_to_nxt) >= RX_TIMEOUT_CYC);
    // set wins over a software clear in the same cycle
    prev_nxt = slot_val;
    ev_nxt = (ev_r & ~ev_clr) | {off_en & prev_r & ~slot_val, on_en & ~prev_r & slot_val};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      link_st_r <= ldcs_pkg::LDCS_LINK_PROTO_ABSENT;
      tx_cnt_r <= 18'h0;
      tx_valid_r <= 1'b0;
      txen_r <= 1'b0;
      tx_sig_r <= 16'h0;
      own_pos_r <= 16'h0;
      own_neg_r <= 16'h0;
      rem_en_r <= 1'b0;
      rem_pos_r <= 16'h0;
      rem_neg_r <= 16'h0;
      rem_sig_r <= 16'h0;
      rx_to_r <= 20'h0;
      comm_fail_r <= 1'b1;
      prev_r <= 16'h0;
      ev_r <= 32'h0;
    end else begin
      link_st_r <= link_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_valid_r <= tx_valid_nxt;
      txen_r <= txen_nxt;
      tx_sig_r <= tx_sig_nxt;
      own_pos_r <= own_pos_nxt;
      own_neg_r <= own_neg_nxt;
      rem_en_r <= rem_en_nxt;
      rem_pos_r <= rem_pos_nxt;
      rem_neg_r <= rem_neg_nxt;
      rem_sig_r <= rem_sig_nxt;
      rx_to_r <= rx_to_nxt;
      comm_fail_r <= comm_fail_nxt;
      prev_r <= prev_nxt;
      ev_r <= ev_nxt;
    end
  end

  // ==================================
  // ct supervision and differential trip
  logic own_nz, own_ld, rem_nz, rem_ld;
  logic [1:0] over_cnt_r, over_cnt_nxt;
  logic [16:0] eff_pick;
  logic ct_fail, inhibit, h2_blk, h5_blk, avail_r, avail_nxt;

  ldcs_seq_ratio u_own_ratio (
    .i_clk(i_clk), .i_rst(i_rst), .i_pos_seq(i_own_pos_seq), .i_neg_seq(i_own_neg_seq),
    .i_ratio_thr(ratio_thr_r), .i_load_thr(load_thr_r),
    .o_ratio_nz(own_nz), .o_loaded(own_ld)); // R1
  ldcs_seq_ratio u_rem_ratio (
    .i_clk(i_clk), .i_rst(i_rst), .i_pos_seq(rem_pos_r), .i_neg_seq(rem_neg_r),
    .i_ratio_thr(ratio_thr_r), .i_load_thr(load_thr_r),
    .o_ratio_nz(rem_nz), .o_loaded(rem_ld)); // R1

  always_comb begin
    // exactly one end asymmetric, and load at both ends
    ct_fail = (own_nz ^ rem_nz) && own_ld && rem_ld && !comm_fail_r; // R2 R3 R4
    alarm_nxt = ct_fail && ctrl_r[`LDCS_CTRL_CTS_EN]; // R5 R22
    eff_pick = (alarm_r && mode == ldcs_pkg::LDCS_MODE_RESTRAIN) ?
               {pickup_r, 1'b0} : {1'b0, pickup_r}; // R6
    h2_blk = ctrl_r[`LDCS_CTRL_H2_EN] && (i_h2_pct > h2_lim_r); // R18
    h5_blk = ctrl_r[`LDCS_CTRL_H5_EN] && (i_h5_pct > h5_lim_r); // R17
    // block mode leaves the line without protection during a real fault
    inhibit = comm_fail_r || h2_blk || h5_blk ||
              (alarm_r && mode == ldcs_pkg::LDCS_MODE_BLOCK); // R7 R19 R8
    over_cnt_nxt = over_cnt_r;
    if (inhibit) begin
      over_cnt_nxt = 2'd0;
    end else if (i_task_tick) begin
      if ({1'b0, i_diff_cur} > eff_pick) begin
        over_cnt_nxt = (over_cnt_r == 2'd2) ? 2'd2 : over_cnt_r + 2'd1; // R20
      end else begin
        over_cnt_nxt = 2'd0;
      end
    end
    trip_nxt = (over_cnt_nxt == 2'd2) && !inhibit; // R20
    avail_nxt = !ctrl_r[`LDCS_CTRL_FIXED]; // R16
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      over_cnt_r <= 2'd0;
      alarm_r <= 1'b0;
      trip_r <= 1'b0;
      avail_r <= 1'b0;
    end else begin
      over_cnt_r <= over_cnt_nxt;
      alarm_r <= alarm_nxt;
      trip_r <= trip_nxt;
      avail_r <= avail_nxt;
    end
  end

  // ==================================
  // outputs
  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;
  assign o_tx_valid = tx_valid_r;
  assign o_tx_enabled = txen_r;
  assign o_tx_pos_seq = own_pos_r;
  assign o_tx_neg_seq = own_neg_r;
  assign o_tx_signals = tx_sig_r;
  assign o_remote_binary_signal = rem_sig_r;
  assign o_link_status = link_st_r;
  assign o_comm_fail = comm_fail_r;
  assign o_cts_alarm = alarm_r;
  assign o_trip = trip_r;
  assign o_freq_stage_avail = avail_r;

  // ==================================
  // checks
  ack_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ack_r |=> !ack_r) else $error("ack held longer than one cycle");
  cts_both_a: assert property (@(posedge i_clk) disable iff (i_rst) // R2
    own_nz && rem_nz |=> !alarm_r) else $error("alarm on fault at both ends");
  cts_load_a: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    !(own_ld && rem_ld) |=> !alarm_r) else $error("alarm without load at both ends");
  block_trip_a: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    alarm_r && mode == ldcs_pkg::LDCS_MODE_BLOCK |=> !trip_r)
    else $error("trip while blocked");
  comm_trip_a: assert property (@(posedge i_clk) disable iff (i_rst) // R19
    comm_fail_r |=> !trip_r) else $error("trip with failed link");
  tx_spacing_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    tx_valid_r |=> !tx_valid_r [*8]) else $error("link updates too close");
  freq_block_a: assert property (@(posedge i_clk) disable iff (i_rst) // R16
    ctrl_r[`LDCS_CTRL_FIXED] |=> !o_freq_stage_avail)
    else $error("frequency stages available in fixed mode");
  link_gate_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    !xfer_ok && !i_rx_valid |=> o_remote_binary_signal == 16'h0)
    else $error("remote signals passed on a disabled link");
  trip_two_a: assert property (@(posedge i_clk) disable iff (i_rst) // R20
    $rose(trip_r) |-> $past(i_task_tick) && $past(over_cnt_r) == 2'd1)
    else $error("trip without two cycles over threshold");
endmodule // ldcs_top

/* File: ldcs_regs.svh */
`ifndef LDCS_REGS_SVH
`define LDCS_REGS_SVH
// ==================================
// register offsets
`define LDCS_CTRL_OFS 8'h00
`define LDCS_RATIO_THR_OFS 8'h04
`define LDCS_PICKUP_OFS 8'h08
`define LDCS_H5_LIM_OFS 8'h0c
`define LDCS_H2_LIM_OFS 8'h10
`define LDCS_LOAD_THR_OFS 8'h14
`define LDCS_STATUS_OFS 8'h18
`define LDCS_REMOTE_OFS 8'h1c
`define LDCS_EVENT_OFS 8'h20
`define LDCS_SLOT_BASE 2'b01
// ==================================
// control fields
`define LDCS_CTRL_LINK_EN 0
`define LDCS_CTRL_MODE_LO 1
`define LDCS_CTRL_CTS_EN 3
`define LDCS_CTRL_FIXED 4
`define LDCS_CTRL_H2_EN 5
`define LDCS_CTRL_H5_EN 6
`define LDCS_CTRL_W 7
// ==================================
// reset values
`define LDCS_CTRL_RST 7'h18
`define LDCS_RATIO_THR_RST 8'h0d
`define LDCS_PICKUP_RST 16'h0100
`define LDCS_H5_LIM_RST 8'h23
`define LDCS_H2_LIM_RST 8'h0f
`define LDCS_LOAD_THR_RST 16'h0010
// ==================================
// slot sources and timing
`define LDCS_SLOTS 16
`define LDCS_SRC_VI_FIRST 1
`define LDCS_SRC_VO_FIRST 5
`define LDCS_SRC_LG_FIRST 11
`define LDCS_SRC_LAST 30
`define LDCS_CLK_KHZ 25000
`define LDCS_TX_PERIOD_MS 10
`define LDCS_RX_TIMEOUT_MS 30
`endif

/* File: ldcs_pkg.sv */
package ldcs_pkg;
  typedef enum logic [1:0] {
    LDCS_MODE_IND = 2'b00,
    LDCS_MODE_RESTRAIN = 2'b01,
    LDCS_MODE_BLOCK = 2'b10
  } ldcs_mode_e;
  typedef enum logic [1:0] {
    LDCS_LINK_PROTO_ABSENT = 2'b00,
    LDCS_LINK_DISABLED = 2'b01,
    LDCS_LINK_OK = 2'b10
  } ldcs_link_e;
endpackage

/* File: ldcs_seq_ratio.sv */
`timescale 1ns/10ps
`include "ldcs_regs.svh"
module ldcs_seq_ratio (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // sequence magnitudes
  input wire logic [15:0] i_pos_seq,
  input wire logic [15:0] i_neg_seq,
  // thresholds
  input wire logic [7:0] i_ratio_thr,
  input wire logic [15:0] i_load_thr,
  // classification
  output logic o_ratio_nz,
  output logic o_loaded
);
  logic ratio_nz_r, ratio_nz_nxt, loaded_r, loaded_nxt;
  logic [23:0] scaled_neg, scaled_pos;

  // ratio in 1/256 steps, compared by cross multiply to avoid a divider
  always_comb begin
    scaled_neg = {i_neg_seq, 8'h00};
    scaled_pos = 24'(i_pos_seq) * 24'(i_ratio_thr);
    ratio_nz_nxt = (scaled_neg > scaled_pos); // R21
    loaded_nxt = (i_pos_seq > i_load_thr);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ratio_nz_r <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      ratio_nz_r <= ratio_nz_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  assign o_ratio_nz = ratio_nz_r;
  assign o_loaded = loaded_r;
endmodule // ldcs_seq_ratio

/* File: ldcs_peer_model.sv */
`timescale 1ns/10ps
// ==================================
// peer relay at the far line end
module ldcs_peer_model #(
  parameter int PER = 20
) (
  // clock and control
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_en,
  input wire logic [15:0] i_pos,
  input wire logic [15:0] i_neg,
  input wire logic [15:0] i_sig,
  // frame toward the block
  output logic o_valid,
  output logic o_enabled,
  output logic [15:0] o_pos,
  output logic [15:0] o_neg,
  output logic [15:0] o_sig
);
  int cnt;
  initial begin
    cnt = 0;
    {o_valid, o_enabled, o_pos, o_neg, o_sig} = '0;
  end
  always @(posedge i_clk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    if (i_run && cnt == PER - 1) begin
      o_valid <= 1'b1;
      o_enabled <= i_en;
      o_pos <= i_pos;
      o_neg <= i_neg;
      o_sig <= i_sig;
    end else begin
      // outside a frame the lines toggle each cycle, so every second cycle repeats the last frame
      o_valid <= 1'b0;
      o_enabled <= ~o_enabled;
      o_pos <= ~o_pos;
      o_neg <= ~o_neg;
      o_sig <= ~o_sig;
    end
  end
endmodule // ldcs_peer_model

/* File: testbench.sv */
`timescale 1ns/10ps
`include "ldcs_regs.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  // ==================================
  // signals
  logic clk, rst, cyc, stb, we, ack, tick, pa, rxv, rxe, txv, txe, cf, alarm, trip, fav;
  logic run, pen;
  logic [7:0] adr, h2, h5;
  logic [31:0] wdat, rdat, q;
  logic [15:0] opos, oneg, diff, rpos, rneg, psig, rxp, rxn, rxs, txp, txn, txs, rbs;
  logic [3:0] vi;
  logic [5:0] vo;
  logic [19:0] lg;
  logic [1:0] lst;
  int error_cnt = 0;
  int tests_run = 0;
  int n;
  ldcs_top #(.TX_PERIOD_CYC(20), .RX_TIMEOUT_CYC(70)) DUT (
    .i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_task_tick(tick), .i_own_pos_seq(opos), .i_own_neg_seq(oneg), .i_diff_cur(diff),
    .i_h2_pct(h2), .i_h5_pct(h5), .i_virtual_input(vi), .i_virtual_output(vo),
    .i_logic_out(lg), .i_proto_assigned(pa), .i_rx_valid(rxv), .i_rx_enabled(rxe),
    .i_rx_pos_seq(rxp), .i_rx_neg_seq(rxn), .i_rx_signals(rxs), .o_tx_valid(txv),
    .o_tx_enabled(txe), .o_tx_pos_seq(txp), .o_tx_neg_seq(txn), .o_tx_signals(txs),
    .o_remote_binary_signal(rbs), .o_link_status(lst), .o_comm_fail(cf),
    .o_cts_alarm(alarm), .o_trip(trip), .o_freq_stage_avail(fav));
  ldcs_peer_model #(.PER(20)) peer (.i_clk(clk), .i_run(run), .i_en(pen), .i_pos(rpos),
    .i_neg(rneg), .i_sig(psig), .o_valid(rxv), .o_enabled(rxe), .o_pos(rxp),
    .o_neg(rxn), .o_sig(rxs));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==================================
  // bus and helper tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 40);
    q = rdat;
    if (k >= 40) error_cnt++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK("read data", e, q)
  endtask
  task automatic w(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic tk();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    w(2);
  endtask
  task automatic trip_seq(input logic [15:0] d);
    @(posedge clk);
    diff <= 16'd0;
    tk();
    tk();
    @(posedge clk);
    diff <= d;
    tk();
    `CHK("trip early", 1'b0, trip)
    tk();
  endtask
  task automatic wait_tx();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (txv !== 1'b1 && n < 60);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==================================
  // tests
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [7] = '{32'h18, 32'h0d, 32'h100, 32'h23, 32'h0f, 32'h10, 32'h2};
  // mode, differential current, expected trip
  logic [1:0] md [5] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd3};
  logic [15:0] dc [5] = '{16'd300, 16'd300, 16'd520, 16'd600, 16'd300};
  logic tx [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  initial begin
    {cyc, stb, we, tick, pa, run, pen, adr, wdat, vi, vo, lg, h2, h5} = '0;
    opos = 16'd100;
    oneg = 16'd50;
    diff = 16'd0;
    rpos = 16'd100;
    rneg = 16'd0;
    psig = 16'ha5c3;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    wb(1'b1, 8'h18, 32'hffffffff);
    rd(8'h18, 32'h2);
    wb(1'b1, 8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    `CHK("freq avail", 1'b0, fav)
    wb(1'b1, 8'h00, 32'h08);
    w(3);
    `CHK("freq avail", 1'b1, fav)
    done("registers");
    wb(1'b1, 8'h00, 32'h18);
    w(3);
    `CHK("link status", 2'd0, lst)
    @(posedge clk);
    pa <= 1'b1;
    w(3);
    `CHK("link status", 2'd1, lst)
    wb(1'b1, 8'h00, 32'h19);
    w(3);
    `CHK("link status", 2'd2, lst)
    `CHK("tx enabled", 1'b1, txe)
    done("status");
    wb(1'b1, 8'h40, 32'h61);
    wb(1'b1, 8'h44, 32'h05);
    wb(1'b1, 8'h48, 32'h0b);
    wb(1'b1, 8'h4c, 32'h1e);
    wb(1'b1, 8'h50, 32'h1f);
    @(posedge clk);
    vi <= 4'h1;
    vo <= 6'h3f;
    lg <= 20'h80001;
    wait_tx();
    wait_tx();
    `CHK("tx period", 20, n)
    `CHK("tx signals", 16'h000f, txs)
    `CHK("tx pos seq", opos, txp)
    `CHK("tx neg seq", oneg, txn)
    @(posedge clk);
    vi <= 4'h0;
    lg <= 20'h80000;
    wait_tx();
    wait_tx();
    `CHK("tx signals", 16'h000a, txs)
    rd(8'h20, 32'h0001_0001);
    wb(1'b1, 8'h20, 32'hffffffff);
    rd(8'h20, 32'h0000_0000);
    done("transmit");
    @(posedge clk);
    run <= 1'b1;
    pen <= 1'b1;
    w(45);
    `CHK("remote signals", psig, rbs)
    `CHK("comm fail", 1'b0, cf)
    @(posedge clk);
    pen <= 1'b0;
    w(45);
    `CHK("remote signals", 16'h0, rbs)
    @(posedge clk);
    pen <= 1'b1;
    w(45);
    `CHK("alarm", 1'b1, alarm)
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h00, 32'h19 | {29'h0, md[i], 1'b0});
      trip_seq(dc[i]);
      `CHK("trip", tx[i], trip)
      `CHK("alarm", 1'b1, alarm)
    end
    done("modes");
    // back to indication mode, block mode only for its own case
    wb(1'b1, 8'h00, 32'h79);
    @(posedge clk);
    h5 <= 8'd36;
    trip_seq(16'd300);
    `CHK("h5 block", 1'b0, trip)
    @(posedge clk);
    h5 <= 8'd35;
    trip_seq(16'd300);
    `CHK("h5 limit", 1'b1, trip)
    @(posedge clk);
    h2 <= 8'd16;
    trip_seq(16'd300);
    `CHK("h2 block", 1'b0, trip)
    wb(1'b1, 8'h00, 32'h59);
    trip_seq(16'd300);
    `CHK("h2 disabled", 1'b1, trip)
    @(posedge clk);
    h2 <= 8'd0;
    done("harmonics");
    @(posedge clk);
    diff <= 16'd0;
    rneg <= 16'd50;
    w(45);
    `CHK("alarm", 1'b0, alarm)
    @(posedge clk);
    rneg <= 16'd0;
    rpos <= 16'd0;
    w(45);
    `CHK("alarm", 1'b0, alarm)
    @(posedge clk);
    rpos <= 16'd100;
    oneg <= 16'd5;
    w(45);
    `CHK("alarm", 1'b0, alarm)
    @(posedge clk);
    oneg <= 16'd6;
    w(45);
    `CHK("alarm", 1'b1, alarm)
    done("supervision");
    @(posedge clk);
    run <= 1'b0;
    diff <= 16'd300;
    w(90);
    `CHK("comm fail", 1'b1, cf)
    `CHK("remote signals", 16'h0, rbs)
    tk();
    tk();
    `CHK("trip", 1'b0, trip)
    done("link loss");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule // testbench
